// ### logic/dea_array.sv
// Data EEPROM storage array with synchronous write and direct read.
`timescale 1ns/1ps
module dea_array #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule : dea_array

// ### logic/dea_pkg.sv
// Constants shared by the data EEPROM access control block.
package dea_pkg;
   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] OFS_INDEX = 8'h00;
   localparam logic [7:0] OFS_BYTE = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_UNLOCK = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN = 8'h8C;
   // ==========================================================
   // Field positions
   localparam int CTL_READ_BIT = 0;
   localparam int CTL_GO_BIT = 1;
   localparam int CTL_PERMIT_BIT = 2;
   localparam int CTL_PWRT_BIT = 3;
   localparam int DONE_BIT = 7;
   localparam logic [7:0] IRQ_EN_MASK = 8'hF7;
   // ==========================================================
   // Reset values and unlock keys
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // ==========================================================
   // Timing and array size
   localparam int CLK_MHZ = 100;
   localparam int PWRT_MS = 72;
   localparam int PWRT_CYCLES = PWRT_MS * CLK_MHZ * 1000;
   localparam int WRITE_CYCLES = 400;
   localparam int KEY_GAP_CYCLES = 8;
   localparam int EE_AW = 7;
   localparam int EE_DW = 8;
endpackage : dea_pkg

// ### logic/dea_top.sv
// Data EEPROM access control with Avalon-MM register slave and interrupt.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Read request outside a running write loads addressed byte two cycles later.
// - Read byte holds until read or write.
// - Write needs 55h, AAh, then go bit.
// - Mistimed unlock sequence stores nothing.
// - Go bit sets only while permit set.
// - Hardware never clears the permit bit.
// - Clearing permit never aborts running write.
// - Completion clears go, sets done flag.
// - Done flag stays until software clears.
// - Permit bit clears at power up.
// - Running power-up timer blocks write start.
module dea_top #(
   parameter int PWRT_COUNT = dea_pkg::PWRT_CYCLES,
   parameter int WRITE_COUNT = dea_pkg::WRITE_CYCLES,
   parameter int KEY_GAP = dea_pkg::KEY_GAP_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic PWRT_ENABLE,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic IRQ
);
   import dea_pkg::*;

   // ==========================================================
   // State
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic [EE_AW-1:0] index_q, index_d;
   logic [7:0] byte_q, byte_d;
   logic rd_q, rd_d;
   logic go_q, go_d;
   logic permit_q, permit_d;
   logic [7:0] flags_q, flags_d;
   logic [7:0] ie_q, ie_d;
   logic irq_q, irq_d;
   logic [EE_AW-1:0] waddr_q, waddr_d;
   logic [7:0] wdata_q, wdata_d;
   logic [31:0] wcnt_q, wcnt_d;
   logic [31:0] pwrt_cnt_q, pwrt_cnt_d;
   logic pwrt_busy_q, pwrt_busy_d;
   logic pwrt_init_q, pwrt_init_d;

   logic acc;
   logic wr_acc;
   logic ctrl_wr;
   logic byte_wr;
   logic key_wr;
   logic armed;
   logic done_pulse;
   logic go_start;
   logic [7:0] mem_rd;
   logic [7:0] ctrl_view;

   // ==========================================================
   // Submodules
   dea_array #(.AW(EE_AW), .DW(EE_DW)) u_array (
      .clk(SYS_CLK),
      .we(done_pulse),
      .waddr(waddr_q),
      .wdata(wdata_q),
      .raddr(index_q),
      .rdata(mem_rd)
   );

   dea_unlock #(.GAP(KEY_GAP)) u_unlock (
      .clk(SYS_CLK),
      .rst(RESET),
      .acc(acc),
      .key_wr(key_wr),
      .key_val(AVS_WRITEDATA[7:0]),
      .armed(armed)
   );

   // ==========================================================
   // Bus decode
   // Each request waits exactly one cycle and is taken on the edge where waitrequest is low.
   assign acc = (AVS_READ || AVS_WRITE) && !wait_q;
   assign wr_acc = AVS_WRITE && !wait_q;
   assign ctrl_wr = wr_acc && AVS_ADDRESS == OFS_CONTROL;
   assign byte_wr = wr_acc && AVS_ADDRESS == OFS_BYTE;
   assign key_wr = wr_acc && AVS_ADDRESS == OFS_UNLOCK;
   assign done_pulse = go_q && wcnt_q == 32'd1;
   assign go_start = ctrl_wr && AVS_WRITEDATA[CTL_GO_BIT] && !go_q && permit_q && armed
      && !pwrt_busy_q;

   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[CTL_READ_BIT] = rd_q;
      ctrl_view[CTL_GO_BIT] = go_q;
      ctrl_view[CTL_PERMIT_BIT] = permit_q;
      ctrl_view[CTL_PWRT_BIT] = pwrt_busy_q;
   end

   always_comb begin
      wait_d = 1'b1;
      rdata_d = rdata_q;
      if ((AVS_READ || AVS_WRITE) && wait_q) begin
         wait_d = 1'b0;
         rdata_d = 32'h0000_0000;
         if (AVS_READ) begin
            case (AVS_ADDRESS)
               OFS_INDEX: rdata_d = {{(32-EE_AW){1'b0}}, index_q};
               OFS_BYTE: rdata_d = {24'h00_0000, byte_q};
               OFS_CONTROL: rdata_d = {24'h00_0000, ctrl_view};
               OFS_FLAGS: rdata_d = {24'h00_0000, flags_q};
               OFS_IRQ_EN: rdata_d = {24'h00_0000, ie_q};
               default: rdata_d = 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Address, data and read path
   always_comb begin
      index_d = index_q;
      byte_d = byte_q;
      rd_d = rd_q;
      if (wr_acc && AVS_ADDRESS == OFS_INDEX) begin
         index_d = AVS_WRITEDATA[EE_AW-1:0];
      end
      if (byte_wr) begin
         byte_d = AVS_WRITEDATA[7:0];
      end
      if (rd_q) begin
         byte_d = mem_rd;
         rd_d = 1'b0;
      end else if (ctrl_wr && AVS_WRITEDATA[CTL_READ_BIT] && !go_q) begin
         rd_d = 1'b1;
      end
   end

   // ==========================================================
   // Write path
   // Address and data are captured at the start, so later register writes cannot disturb a running cycle.
   always_comb begin
      go_d = go_q;
      permit_d = permit_q;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      wcnt_d = wcnt_q;
      if (ctrl_wr) begin
         permit_d = AVS_WRITEDATA[CTL_PERMIT_BIT];
      end
      if (go_start) begin
         go_d = 1'b1;
         waddr_d = index_q;
         wdata_d = byte_q;
         wcnt_d = 32'(WRITE_COUNT);
      end else if (go_q) begin
         wcnt_d = wcnt_q - 32'd1;
         if (done_pulse) begin
            go_d = 1'b0;
         end
      end
   end

   // ==========================================================
   // Power-up timer
   // The enable level is caught on the first clock after reset release.
   always_comb begin
      pwrt_init_d = 1'b0;
      pwrt_busy_d = pwrt_busy_q;
      pwrt_cnt_d = pwrt_cnt_q;
      if (pwrt_init_q) begin
         pwrt_busy_d = PWRT_ENABLE;
         pwrt_cnt_d = 32'(PWRT_COUNT);
      end else if (pwrt_busy_q) begin
         pwrt_cnt_d = pwrt_cnt_q - 32'd1;
         if (pwrt_cnt_q <= 32'd1) begin
            pwrt_busy_d = 1'b0;
         end
      end
   end

   // ==========================================================
   // Flags and interrupt
   // A completion in the same cycle as a clear leaves the flag set.
   always_comb begin
      flags_d = flags_q;
      ie_d = ie_q;
      if (wr_acc && AVS_ADDRESS == OFS_FLAGS && AVS_WRITEDATA[DONE_BIT]) begin
         flags_d[DONE_BIT] = 1'b0;
      end
      if (done_pulse) begin
         flags_d[DONE_BIT] = 1'b1;
      end
      if (wr_acc && AVS_ADDRESS == OFS_IRQ_EN) begin
         ie_d = AVS_WRITEDATA[7:0] & IRQ_EN_MASK;
      end
      irq_d = |(flags_d & ie_d);
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         index_q <= '0;
         byte_q <= BYTE_RESET;
         rd_q <= 1'b0;
         go_q <= 1'b0;
         permit_q <= 1'b0;
         flags_q <= FLAGS_RESET;
         ie_q <= IRQ_EN_RESET;
         irq_q <= 1'b0;
         waddr_q <= '0;
         wdata_q <= 8'h00;
         wcnt_q <= 32'h0000_0000;
         pwrt_cnt_q <= 32'h0000_0000;
         pwrt_busy_q <= 1'b1;
         pwrt_init_q <= 1'b1;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         index_q <= index_d;
         byte_q <= byte_d;
         rd_q <= rd_d;
         go_q <= go_d;
         permit_q <= permit_d;
         flags_q <= flags_d;
         ie_q <= ie_d;
         irq_q <= irq_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wcnt_q <= wcnt_d;
         pwrt_cnt_q <= pwrt_cnt_d;
         pwrt_busy_q <= pwrt_busy_d;
         pwrt_init_q <= pwrt_init_d;
      end
   end

   assign AVS_WAITREQUEST = wait_q;
   assign AVS_READDATA = rdata_q;
   assign IRQ = irq_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   rd_load_a: assert property (rd_q |=> !rd_q && byte_q == $past(mem_rd))
      else $error("read byte not loaded on the next cycle");
   rd_start_a: assert property (ctrl_wr && AVS_WRITEDATA[CTL_READ_BIT] && !go_q ##1 1'b1
      |=> byte_q == $past(mem_rd) && !rd_q)
      else $error("read request did not complete in two cycles");
   byte_hold_a: assert property (!rd_q && !byte_wr |=> $stable(byte_q))
      else $error("read byte changed without cause");
   go_permit_a: assert property ($rose(go_q) |-> $past(permit_q))
      else $error("write started without permit");
   go_key_a: assert property ($rose(go_q) |-> $past(armed) && $past(ctrl_wr))
      else $error("write started without unlock sequence");
   permit_hold_a: assert property (!ctrl_wr |=> $stable(permit_q))
      else $error("permit bit changed without a control write");
   write_run_a: assert property (go_q && wcnt_q > 32'd1 |=> go_q && wcnt_q == $past(wcnt_q) - 32'd1)
      else $error("running write was disturbed");
   done_set_a: assert property (done_pulse |=> !go_q && flags_q[DONE_BIT]
      ##1 irq_q == (ie_q[DONE_BIT] && flags_q[DONE_BIT]))
      else $error("completion did not clear go and set flag");
   flag_sticky_a: assert property (flags_q[DONE_BIT] && !(wr_acc && AVS_ADDRESS == OFS_FLAGS)
      |=> flags_q[DONE_BIT])
      else $error("done flag cleared by hardware");
   pwrt_block_a: assert property ($rose(go_q) |-> !$past(pwrt_busy_q))
      else $error("write started during power-up timer");

   // Every request waits one cycle and is then answered for exactly one cycle.
   wait_answer_a: assert property ((AVS_READ || AVS_WRITE) && wait_q |=> !wait_q)
      else $error("request not answered after one wait cycle");
   wait_pulse_a: assert property (!wait_q |=> wait_q)
      else $error("waitrequest stayed low for more than one cycle");

   // The permit bit and the power-up timer guard the first writes after reset.
   permit_reset_a: assert property ($fell(RESET) |-> !permit_q)
      else $error("permit bit set after reset");
   pwrt_off_a: assert property (pwrt_init_q && !PWRT_ENABLE |=> !pwrt_busy_q)
      else $error("disabled power-up timer still blocks writes");
   pwrt_run_a: assert property (pwrt_busy_q && !pwrt_init_q && pwrt_cnt_q > 32'd1 |=> pwrt_busy_q)
      else $error("power-up timer ended early");

   // A started write runs to its end and the keys must be given again for the next byte.
   go_hold_a: assert property (go_q && !done_pulse |=> go_q)
      else $error("running write aborted");
   key_again_a: assert property ($rose(go_q) |-> !armed)
      else $error("unlock stayed armed after a write start");
   flag_clear_a: assert property (wr_acc && AVS_ADDRESS == OFS_FLAGS && AVS_WRITEDATA[DONE_BIT] && !done_pulse
      |=> !flags_q[DONE_BIT])
      else $error("done flag not cleared by software");
endmodule : dea_top

// ### logic/dea_unlock.sv
// Unlock key sequence tracker for the data EEPROM write start.
`timescale 1ns/1ps
module dea_unlock #(
   parameter int GAP = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic acc,
   input wire logic key_wr,
   input wire logic [7:0] key_val,
   output logic armed
);
   import dea_pkg::*;

   typedef enum logic [1:0] {KS_IDLE, KS_FIRST, KS_SECOND} dea_key_t;
   dea_key_t state_q, state_d;
   logic [7:0] gap_q, gap_d;

   // ==========================================================
   // Sequence state
   always_comb begin
      state_d = state_q;
      gap_d = (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;
      if (state_q != KS_IDLE && gap_q >= 8'(GAP)) begin
         state_d = KS_IDLE;
      end
      if (acc) begin
         gap_d = 8'h00;
         case (state_q)
            KS_FIRST: state_d = (key_wr && key_val == KEY_SECOND) ? KS_SECOND : KS_IDLE;
            default: state_d = KS_IDLE;
         endcase
         if (key_wr && key_val == KEY_FIRST) begin
            state_d = KS_FIRST;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= KS_IDLE;
         gap_q <= 8'h00;
      end else begin
         state_q <= state_d;
         gap_q <= gap_d;
      end
   end

   // Only the very next access after the second key, inside the gap window, may start a write.
   assign armed = (state_q == KS_SECOND) && (gap_q < 8'(GAP));
endmodule : dea_unlock

// ### test/test_dea_top.sv
// Self-checking testbench for the data EEPROM access control block.
`timescale 1ns/1ps
module test_dea_top;
   import dea_pkg::*;
   // ==========================================================
   // Clock, reset and bus signals
   localparam int PWRT_SIM = 40;
   localparam int WRITE_SIM = 30;
   localparam int LIMIT = 5000;
   logic SYS_CLK = 1'b0;
   logic RESET = 1'b1;
   logic PWRT_ENABLE = 1'b1;
   logic [7:0] AVS_ADDRESS = 8'h00;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic IRQ;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   logic [7:0] rd = 8'h00;
   always #5 SYS_CLK = ~SYS_CLK;
   dea_top #(.PWRT_COUNT(PWRT_SIM), .WRITE_COUNT(WRITE_SIM), .KEY_GAP(KEY_GAP_CYCLES)) dea_top_inst (
      .SYS_CLK(SYS_CLK),
      .RESET(RESET),
      .PWRT_ENABLE(PWRT_ENABLE),
      .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .IRQ(IRQ)
   );
   // ==========================================================
   // Report, compare and bus tasks
   task automatic end_sim;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8
   task automatic chk1(input string what, input logic exp);
      compares++;
      if (IRQ !== exp) begin
         errors++;
         $display("mismatch %s expected %b seen %b", what, exp, IRQ);
      end
   endtask : chk1
   // The request is held until the edge that samples waitrequest low.
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge SYS_CLK);
      AVS_ADDRESS <= addr;
      AVS_WRITEDATA <= {24'h0, data};
      AVS_WRITE <= wr;
      AVS_READ <= ~wr;
      @(posedge SYS_CLK);
      while (AVS_WAITREQUEST !== 1'b0) @(posedge SYS_CLK);
      rd = AVS_READDATA[7:0];
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      bus(1'b1, addr, data);
   endtask : wr
   task automatic rdc(input logic [7:0] addr, input logic [7:0] exp, input string what);
      bus(1'b0, addr, 8'h00);
      chk8(what, exp, rd);
   endtask : rdc
   task automatic unlock;
      wr(OFS_UNLOCK, KEY_FIRST);
      wr(OFS_UNLOCK, KEY_SECOND);
   endtask : unlock
   // Polls the control register until the selected bit drops.
   task automatic wait_clear(input int bitpos);
      for (int i = 0; i < 40; i++) begin
         bus(1'b0, OFS_CONTROL, 8'h00);
         if (rd[bitpos] === 1'b0) begin
            break;
         end
      end
   endtask : wait_clear
   task automatic irq_after(input string what, input logic exp);
      repeat (2) @(posedge SYS_CLK);
      chk1(what, exp);
   endtask : irq_after
   // ==========================================================
   // Timeout
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         end_sim();
      end
   end
   // ==========================================================
   // Test sequence
   initial begin
      repeat (4) @(posedge SYS_CLK);
      RESET <= 1'b0;
      rdc(OFS_CONTROL, 8'h08, "control reset");
      wr(OFS_CONTROL, 8'h04);
      unlock();
      wr(OFS_CONTROL, 8'h06);
      rdc(OFS_CONTROL, 8'h0C, "go during timer");
      wait_clear(CTL_PWRT_BIT);
      chk8("control after timer", 8'h04, rd);
      rdc(OFS_FLAGS, FLAGS_RESET, "flags reset");
      rdc(OFS_IRQ_EN, IRQ_EN_RESET, "irq enables reset");
      wr(OFS_INDEX, 8'h05);
      wr(OFS_BYTE, 8'hA5);
      unlock();
      wr(OFS_CONTROL, 8'h06);
      wr(OFS_IRQ_EN, 8'h80);
      rdc(OFS_CONTROL, 8'h06, "control busy");
      wr(OFS_CONTROL, 8'h00);
      rdc(OFS_CONTROL, 8'h02, "permit off mid write");
      wait_clear(CTL_GO_BIT);
      chk8("control after write", 8'h00, rd);
      rdc(OFS_FLAGS, 8'h80, "done flag");
      chk1("irq on done", 1'b1);
      repeat (20) @(posedge SYS_CLK);
      rdc(OFS_FLAGS, 8'h80, "done flag held");
      wr(OFS_IRQ_EN, 8'h00);
      irq_after("irq masked", 1'b0);
      wr(OFS_IRQ_EN, 8'h80);
      irq_after("irq unmasked", 1'b1);
      wr(OFS_FLAGS, 8'h80);
      irq_after("irq cleared", 1'b0);
      rdc(OFS_FLAGS, 8'h00, "flag cleared");
      wr(OFS_BYTE, 8'h00);
      wr(OFS_CONTROL, 8'h01);
      rdc(OFS_BYTE, 8'hA5, "read byte");
      rdc(OFS_CONTROL, 8'h00, "read request cleared");
      rdc(OFS_BYTE, 8'hA5, "read byte held");
      unlock();
      wr(OFS_CONTROL, 8'h02);
      rdc(OFS_CONTROL, 8'h00, "go without permit");
      wr(OFS_CONTROL, 8'h04);
      wr(OFS_BYTE, 8'h11);
      rdc(OFS_BYTE, 8'h11, "byte written");
      wr(OFS_UNLOCK, KEY_SECOND);
      wr(OFS_UNLOCK, KEY_FIRST);
      wr(OFS_CONTROL, 8'h06);
      rdc(OFS_CONTROL, 8'h04, "keys reversed");
      wr(OFS_UNLOCK, KEY_FIRST);
      rdc(OFS_FLAGS, 8'h00, "flags between keys");
      wr(OFS_UNLOCK, KEY_SECOND);
      wr(OFS_CONTROL, 8'h06);
      rdc(OFS_CONTROL, 8'h04, "keys interrupted");
      wr(OFS_UNLOCK, KEY_FIRST);
      repeat (KEY_GAP_CYCLES) @(posedge SYS_CLK);
      wr(OFS_UNLOCK, KEY_SECOND);
      wr(OFS_CONTROL, 8'h06);
      rdc(OFS_CONTROL, 8'h04, "keys too slow");
      wr(OFS_CONTROL, 8'h05);
      rdc(OFS_BYTE, 8'hA5, "memory unchanged");
      rdc(8'h40, 8'h00, "unmapped read");
      rdc(OFS_UNLOCK, 8'h00, "unlock port read");
      wr(OFS_IRQ_EN, 8'hFF);
      rdc(OFS_IRQ_EN, IRQ_EN_MASK, "irq enables mask");
      // A second reset with the power-up timer disabled lets a write start at once.
      PWRT_ENABLE <= 1'b0;
      RESET <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      RESET <= 1'b0;
      rdc(OFS_CONTROL, 8'h00, "control after reset");
      chk1("irq after reset", 1'b0);
      wr(OFS_CONTROL, 8'h04);
      wr(OFS_BYTE, 8'h5A);
      unlock();
      wr(OFS_CONTROL, 8'h06);
      wr(OFS_BYTE, 8'h3C);
      wr(OFS_CONTROL, 8'h05);
      rdc(OFS_BYTE, 8'h3C, "read refused while busy");
      rdc(OFS_CONTROL, 8'h06, "go without timer");
      wait_clear(CTL_GO_BIT);
      rdc(OFS_FLAGS, 8'h80, "done flag again");
      wr(OFS_CONTROL, 8'h01);
      rdc(OFS_BYTE, 8'h5A, "write verify");
      end_sim();
   end
endmodule : test_dea_top
